// *** src/carrier_fifo.sv ***
// Show-ahead FIFO in front of the mapper.
// Assumes one clock; full is registered for a clean ready.
`default_nettype none
module carrier_fifo
    import mapper_pkg::*;
#(
    parameter int WIDTH = SYM_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          full;
    } fifo_s;

    fifo_s            st_ff;
    fifo_s            nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = !st_ff.full;
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = mem[st_ff.rp];
    assign push      = in_valid && !st_ff.full;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop)
        begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt  = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_st.full = (nxt_st.cnt == (AW+1)'(DEPTH));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // No reset: nothing is read before it is written
    always_ff @(posedge hclk)
    begin
        if (push)
        begin
            mem[st_ff.wp] <= in_data;
        end
    end
endmodule : carrier_fifo
`default_nettype wire

// *** src/mapper_pkg.sv ***
// Constants and types of the carrier mapper.
// Assumes a 36 carrier band.
`default_nettype none
package mapper_pkg;
    localparam int          NUM_CAR      = 36;
    localparam int          CAR_W        = 6;
    localparam logic [5:0]  LAST_CAR     = 6'h23;
    localparam int          SYM_W        = 3;
    localparam int          CNT_W        = 9;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          TBL_W        = 10;
    localparam int          TBL_DEPTH    = 64;
    localparam int          SECT_LEN     = 9;
    // Filler LFSR x^7 + x^4 + 1
    localparam int          PN_W         = 7;
    localparam logic [6:0]  PN_SEED      = 7'h7f;
    localparam int          PN_TAP_A     = 6;
    localparam int          PN_TAP_B     = 3;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_TABLE    = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_THRESH   = 8'h0c;
    localparam logic [7:0]  OFS_MAP_LO   = 8'h10;
    localparam logic [7:0]  OFS_MAP_HI   = 8'h14;
    localparam logic [7:0]  OFS_RESP     = 8'h18;
    // Field positions
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_TMR_BIT   = 2;
    localparam int          CTRL_POWER_LSB = 4;
    localparam int          TBL_GAIN_LSB   = 0;
    localparam int          TBL_MASK_BIT   = 8;
    localparam int          TBL_MAP_BIT    = 9;
    localparam int          TBL_CAR_LSB    = 16;
    localparam int          STAT_RESP_BIT  = 0;
    // Reset values
    localparam logic [23:0] THRESH_RST   = 24'h302010;
    localparam logic [3:0]  POWER_RST    = 4'h0;
    localparam logic [7:0]  SNR_MAX      = 8'hff;

    typedef enum logic [1:0] {
        MODE_ROBUST = 2'b00,
        MODE_BPSK   = 2'b01,
        MODE_QPSK   = 2'b10,
        MODE_8PSK   = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_MAP   = 2'b10
    } map_state_e;
endpackage : mapper_pkg
`default_nettype wire

// *** src/tone_mapped_carrier_mapper.sv ***
// Carrier mapper and tone map estimator behind
// an AHB-Lite slave.
// Assumes one symbol word per data carrier and
// one carrier per output handshake.
// Functional notes
// - Masked carriers get zero amplitude, no phase.
// - Differential modes also obey the tone map.
// - Unmasked idle carriers carry a filler bit.
// - Filler bit copied onto the symbol bits the mode carries.
// - Filler generator loaded with ones every frame.
// - Generator steps after every carrier, any kind.
// - Output 1 on carrier 0, output 37 next symbol.
// - Receiver picks usable tones and mode from SNR.
// - Receiver reports power level and section gains.
// - Dummy tones signalled, sent as filler, discarded.
// - Tone map request flag asks peer for estimate.
// - Estimate finished gives a tone map response.
// - Broadcast frames always robust.
`default_nettype none
module tone_mapped_carrier_mapper
    import mapper_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             in_valid,
    input  wire logic [SYM_W-1:0] in_bits,
    output logic                  in_ready,
    input  wire logic             frame_start,
    input  wire logic             frame_broadcast,
    input  wire logic [CNT_W-1:0] frame_symbols,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [CAR_W-1:0] out_carrier,
    output logic      [SYM_W-1:0] out_bits,
    output logic                  out_active,
    output logic      [7:0]       out_gain,
    output logic                  out_filler,
    output logic                  out_last,
    input  wire logic             snr_valid,
    input  wire logic [CAR_W-1:0] snr_carrier,
    input  wire logic [7:0]       snr_value,
    input  wire logic             snr_last,
    input  wire logic             rx_tone_map_request_flag,
    output logic                  tx_tone_map_request_flag,
    input  wire logic             rx_sym_valid,
    input  wire logic [CAR_W-1:0] rx_sym_carrier,
    output logic                  rx_keep_valid,
    output logic                  rx_keep
);
    typedef struct packed {
        logic                 a_wr;
        logic [7:0]           a_addr;
        logic [31:0]          rdata;
        mode_e                ctrl_mode;
        logic                 ctrl_tmr;
        logic [3:0]           ctrl_power;
        logic [23:0]          thresh;
        logic                 resp_ready;
        logic                 req_pend;
        logic [NUM_CAR-1:0]   est_map;
        logic [7:0]           est_min;
        logic [3:0]           est_weak;
        logic [NUM_CAR-1:0]   resp_map;
        mode_e                resp_mode;
        logic [3:0]           resp_power;
        logic [3:0]           resp_boost;
        map_state_e           mst;
        logic [CAR_W-1:0]     car;
        logic [CNT_W-1:0]     sym;
        logic [CNT_W-1:0]     sym_total;
        mode_e                fmode;
        logic [PN_W-1:0]      pn;
        logic                 o_valid;
        logic [CAR_W-1:0]     o_car;
        logic [SYM_W-1:0]     o_bits;
        logic                 o_active;
        logic [7:0]           o_gain;
        logic                 o_filler;
        logic                 o_last;
        logic                 k_valid;
        logic                 k_keep;
    } state_s;

    state_s           st_ff;
    state_s           nxt_st;
    logic             tbl_we;
    logic [TBL_W-1:0] tbl_rdata;
    logic             f_valid;
    logic [SYM_W-1:0] f_data;
    logic             f_pop;
    logic             pn_bit;
    logic             masked;
    logic             data_car;

    // Spectrum section of a carrier
    function automatic logic [1:0] section_of(input logic [CAR_W-1:0] c);
        if (c < 6'(SECT_LEN))
            return 2'd0;
        else if (c < 6'(2 * SECT_LEN))
            return 2'd1;
        else if (c < 6'(3 * SECT_LEN))
            return 2'd2;
        return 2'd3;
    endfunction : section_of

    // Keep the bits the mode carries
    function automatic logic [SYM_W-1:0] trim_bits(input mode_e m,
                                                   input logic [2:0] b);
        case (m)
            MODE_8PSK: return b;
            MODE_QPSK: return {1'b0, b[1:0]};
            default:   return {2'b00, b[0]};
        endcase
    endfunction : trim_bits

    assign tbl_we = st_ff.a_wr && (st_ff.a_addr == OFS_TABLE);
    assign pn_bit = st_ff.pn[PN_TAP_A] ^ st_ff.pn[PN_TAP_B];
    assign masked = tbl_rdata[TBL_MASK_BIT];
    // Robust uses every unmasked tone; others use the map
    assign data_car = !masked && (st_ff.fmode == MODE_ROBUST
                                  || tbl_rdata[TBL_MAP_BIT]);

    tone_table_mem #(
        .WIDTH (TBL_W),
        .DEPTH (TBL_DEPTH)
    ) u_table (
        .clk   (hclk),
        .we    (tbl_we),
        .waddr (hwdata[TBL_CAR_LSB +: CAR_W]),
        .wdata (hwdata[TBL_W-1:0]),
        .raddr (st_ff.car),
        .rdata (tbl_rdata)
    );

    carrier_fifo #(
        .WIDTH (SYM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (in_valid),
        .in_data   (in_bits),
        .in_ready  (in_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    // Outputs from the state register; hreadyout and hresp are tied off
    assign hrdata                   = st_ff.rdata;
    assign hreadyout                = 1'b1;
    assign hresp                    = 1'b0;
    assign out_valid                = st_ff.o_valid;
    assign out_carrier              = st_ff.o_car;
    assign out_bits                 = st_ff.o_bits;
    assign out_active               = st_ff.o_active;
    assign out_gain                 = st_ff.o_gain;
    assign out_filler               = st_ff.o_filler;
    assign out_last                 = st_ff.o_last;
    assign tx_tone_map_request_flag = st_ff.ctrl_tmr;
    assign rx_keep_valid            = st_ff.k_valid;
    assign rx_keep                  = st_ff.k_keep;

    // Next state of the whole block
    always_comb
    begin
        nxt_st = st_ff;
        f_pop  = 1'b0;

        // Write data phase; unmapped offsets dropped
        if (st_ff.a_wr)
        begin
            case (st_ff.a_addr)
                OFS_CTRL:
                begin
                    nxt_st.ctrl_mode  = mode_e'(hwdata[CTRL_MODE_LSB +: 2]);
                    nxt_st.ctrl_tmr   = hwdata[CTRL_TMR_BIT];
                    nxt_st.ctrl_power = hwdata[CTRL_POWER_LSB +: 4];
                end
                OFS_THRESH: nxt_st.thresh = hwdata[23:0];
                OFS_STATUS:
                begin
                    if (hwdata[STAT_RESP_BIT])
                    begin
                        nxt_st.resp_ready = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Address phase; read data stands in the data phase
        nxt_st.a_wr = 1'b0;
        if (hsel && hready && htrans == HTRANS_NSEQ)
        begin
            nxt_st.a_wr   = hwrite;
            nxt_st.a_addr = haddr[7:0];
            if (!hwrite)
            begin
                case (haddr[7:0])
                    OFS_CTRL:   nxt_st.rdata = {24'h0, st_ff.ctrl_power,
                                    1'b0, st_ff.ctrl_tmr, st_ff.ctrl_mode};
                    OFS_STATUS: nxt_st.rdata = {29'h0,
                                    st_ff.mst != ST_IDLE, st_ff.req_pend,
                                    st_ff.resp_ready};
                    OFS_THRESH: nxt_st.rdata = {8'h0, st_ff.thresh};
                    OFS_MAP_LO: nxt_st.rdata = st_ff.resp_map[31:0];
                    OFS_MAP_HI: nxt_st.rdata = {28'h0,
                                    st_ff.resp_map[NUM_CAR-1:32]};
                    OFS_RESP:   nxt_st.rdata = {20'h0, st_ff.resp_boost,
                                    st_ff.resp_power, 2'b00,
                                    st_ff.resp_mode};
                    default:    nxt_st.rdata = 32'h0;
                endcase
            end
        end

        // Tone SNR decides use and weakest used tone
        if (snr_valid && snr_carrier <= LAST_CAR)
        begin
            nxt_st.est_map[snr_carrier] = (snr_value >= st_ff.thresh[7:0]);
            if (snr_value < st_ff.thresh[7:0])
            begin
                nxt_st.est_weak[section_of(snr_carrier)] = 1'b1;
            end
            else if (snr_value < st_ff.est_min)
            begin
                nxt_st.est_min = snr_value;
            end
        end

        // End of estimate: publish the response
        if (snr_valid && snr_last)
        begin
            nxt_st.resp_map   = nxt_st.est_map;
            nxt_st.resp_power = st_ff.ctrl_power;
            nxt_st.resp_boost = nxt_st.est_weak;
            if (nxt_st.est_map == '0)
                nxt_st.resp_mode = MODE_ROBUST;
            else if (nxt_st.est_min >= st_ff.thresh[23:16])
                nxt_st.resp_mode = MODE_8PSK;
            else if (nxt_st.est_min >= st_ff.thresh[15:8])
                nxt_st.resp_mode = MODE_QPSK;
            else
                nxt_st.resp_mode = MODE_BPSK;
            nxt_st.est_map  = '0;
            nxt_st.est_min  = SNR_MAX;
            nxt_st.est_weak = '0;
            if (st_ff.req_pend)
            begin
                nxt_st.resp_ready = 1'b1;
                nxt_st.req_pend   = 1'b0;
            end
        end

        // Request with end of estimate stays pending
        if (rx_tone_map_request_flag)
        begin
            nxt_st.req_pend = 1'b1;
        end

        // Dummy tones we asked for are discarded
        nxt_st.k_valid = rx_sym_valid;
        nxt_st.k_keep  = rx_sym_valid && rx_sym_carrier <= LAST_CAR
                         && st_ff.resp_map[rx_sym_carrier];

        // Handshake retires the held carrier
        if (st_ff.o_valid && out_ready)
        begin
            nxt_st.o_valid = 1'b0;
        end

        case (st_ff.mst)
            ST_IDLE:
            begin
                if (frame_start && frame_symbols != '0)
                begin
                    nxt_st.pn        = PN_SEED;
                    nxt_st.car       = '0;
                    nxt_st.sym       = '0;
                    nxt_st.sym_total = frame_symbols;
                    nxt_st.fmode     = frame_broadcast ? MODE_ROBUST
                                                       : st_ff.ctrl_mode;
                    nxt_st.mst       = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                // Table data for the carrier lands next cycle
                nxt_st.mst = ST_MAP;
            end
            ST_MAP:
            begin
                if ((!st_ff.o_valid || out_ready) && (!data_car || f_valid))
                begin
                    f_pop             = data_car;
                    nxt_st.o_valid    = 1'b1;
                    nxt_st.o_car      = st_ff.car;
                    nxt_st.o_active   = !masked;
                    nxt_st.o_gain     = masked ? 8'h00
                                               : tbl_rdata[TBL_GAIN_LSB +: 8];
                    nxt_st.o_filler   = !masked && !data_car;
                    if (masked)
                        nxt_st.o_bits = '0;
                    else if (data_car)
                        nxt_st.o_bits = trim_bits(st_ff.fmode, f_data);
                    else
                        nxt_st.o_bits = trim_bits(st_ff.fmode,
                                                  {SYM_W{pn_bit}});
                    // Step on every carrier: symbol 2 starts at 37
                    nxt_st.pn = {st_ff.pn[PN_W-2:0], pn_bit};
                    nxt_st.o_last = (st_ff.car == LAST_CAR)
                                    && (st_ff.sym == st_ff.sym_total - 1'b1);
                    if (nxt_st.o_last)
                    begin
                        nxt_st.mst = ST_IDLE;
                    end
                    else
                    begin
                        nxt_st.mst = ST_FETCH;
                        if (st_ff.car == LAST_CAR)
                        begin
                            nxt_st.car = '0;
                            nxt_st.sym = st_ff.sym + 1'b1;
                        end
                        else
                        begin
                            nxt_st.car = st_ff.car + 1'b1;
                        end
                    end
                end
            end
            default: nxt_st.mst = ST_IDLE;
        endcase
    end

    // All state in one register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff            <= '0;
            st_ff.thresh     <= THRESH_RST;
            st_ff.ctrl_power <= POWER_RST;
            st_ff.est_min    <= SNR_MAX;
            st_ff.pn         <= PN_SEED;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule : tone_mapped_carrier_mapper
`default_nettype wire

// *** src/tone_table_mem.sv ***
// Per-carrier gain, mask and tone map bits.
// One bus write port, one registered read port.
`default_nettype none
module tone_table_mem
    import mapper_pkg::*;
#(
    parameter int WIDTH = TBL_W,
    parameter int DEPTH = TBL_DEPTH
)(
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    // No reset; software loads it before a frame
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : tone_table_mem
`default_nettype wire

// *** testbench/carrier_sink.sv ***
// IFFT input model: one carrier per handshake.
// Stalls one cycle in three.
`default_nettype none
module carrier_sink
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic out_valid,
    output logic      out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick_ff;
    // Stalls force the mapper to hold a carrier
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_ff <= 2'h0;
        else if (out_valid)
            tick_ff <= (tick_ff == 2'h2) ? 2'h0 : tick_ff + 2'h1;
    end
    assign out_ready = (tick_ff != 2'h0);
endmodule : carrier_sink
`default_nettype wire

// *** testbench/mapper_assertions.sv ***
// Checker: carrier stream, bus answer, keep strobe.
// Assumes binding into the mapper top; one clock.
`default_nettype none
module mapper_checker
    import mapper_pkg::*;
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic             out_valid,
    input wire logic             out_ready,
    input wire logic [CAR_W-1:0] out_carrier,
    input wire logic [SYM_W-1:0] out_bits,
    input wire logic             out_active,
    input wire logic [7:0]       out_gain,
    input wire logic             out_filler,
    input wire logic             out_last,
    input wire logic             rx_sym_valid,
    input wire logic             rx_keep_valid
);
    logic             first_ff;
    logic [CAR_W-1:0] prev_ff;
    // Last carrier taken
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            first_ff <= 1'b1;
            prev_ff  <= '0;
        end
        else if (out_valid && out_ready)
        begin
            first_ff <= out_last;
            prev_ff  <= out_carrier;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_taken;
        out_valid && out_ready;
    endsequence
    sequence s_refetch;
        !out_valid || out_carrier != $past(out_carrier);
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    a_refetch_gap: assert property (s_taken |=> s_refetch)
        else $error("carrier issued twice");
    a_stall_hold: assert property (out_valid && !out_ready |=> out_valid
        && $stable({out_carrier, out_bits, out_active, out_gain}))
        else $error("stall not held");
    a_masked_silent: assert property (out_valid && !out_active |->
        out_bits == 3'h0 && out_gain == 8'h0 && !out_filler)
        else $error("mask not silent");
    a_filler_copy: assert property (out_valid && out_filler |->
        out_active && out_bits inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("bad filler");
    a_last_carrier: assert property (out_valid && out_last |->
        out_carrier == LAST_CAR)
        else $error("bad last carrier");
    a_carrier_order: assert property (out_valid |-> out_carrier ==
        ((first_ff || prev_ff == LAST_CAR) ? '0 : prev_ff + 1'b1))
        else $error("carrier out of order");
    a_keep_delay: assert property (rx_sym_valid |=> rx_keep_valid)
        else $error("keep strobe missing");
    a_keep_only: assert property (!rx_sym_valid |=> !rx_keep_valid)
        else $error("stray keep");
endmodule : mapper_checker
bind tone_mapped_carrier_mapper mapper_checker u_chk (.*);
`default_nettype wire

// *** testbench/tone_mapped_carrier_mapper_bench.sv ***
// Bench: registers, frame mapping, estimator.
// Assumes carrier_sink paces out_ready.
`default_nettype none
module tone_mapped_carrier_mapper_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mapper_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, in_bits, out_bits;
    logic        in_valid, in_ready, frame_start, frame_broadcast;
    logic [8:0]  frame_symbols;
    logic        out_valid, out_ready, out_active, out_filler, out_last;
    logic [5:0]  out_carrier, snr_carrier, rx_sym_carrier;
    logic [7:0]  out_gain, snr_value;
    logic        snr_valid, snr_last, rx_sym_valid, rx_keep_valid, rx_keep;
    logic        rx_tone_map_request_flag, tx_tone_map_request_flag;
    int          err_count, check_count;
    assign hready = hreadyout;
    tone_mapped_carrier_mapper u_dut (.*);
    carrier_sink u_sink (.hclk, .hresetn, .out_valid, .out_ready);
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One AHB transfer, waits on hready
    task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= HTRANS_NSEQ;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, logic [31:0] m, x);
        bus(1'b0, a, 32'h0);
        chk(rd & m, x);
    endtask : rdchk
    task automatic test_regs();
        logic [7:0]  ofs [5] = '{OFS_CTRL, OFS_THRESH, OFS_STATUS,
                                 OFS_RESP, 8'h1c};
        logic [31:0] rst [5] = '{32'h0, {8'h0, THRESH_RST}, 32'h0,
                                 32'h0, 32'h0};
        foreach (ofs[i]) rdchk(ofs[i], '1, rst[i]);
        bus(1'b1, 8'h1c, 32'hffff_ffff);
        rdchk(8'h1c, '1, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h4);
        @(posedge hclk);
        chk({31'h0, tx_tone_map_request_flag}, 32'h1);
        // Mask c%7==3, map off on c%3==0
        for (int c = 0; c < NUM_CAR; c++)
            bus(1'b1, OFS_TABLE, (c << 16) | ((c % 3 != 0) << 9)
                | ((c % 7 == 3) << 8) | (c + 1));
        $display("test_regs done");
    endtask : test_regs
    // Two symbol frame, filler from a reference LFSR
    task automatic run_frame(input logic [1:0] md, input logic bc);
        logic [6:0]  s;
        logic [2:0]  wm, wd;
        logic        rb, dat, p;
        int          nd, k;
        logic [31:0] ex;
        s = 7'h7f;
        rb = bc || md == MODE_ROBUST;
        wm = (rb || md == MODE_BPSK) ? 3'h1 : (md == MODE_QPSK) ? 3'h3 : 3'h7;
        nd = 0;
        k = 0;
        for (int c = 0; c < NUM_CAR; c++)
            nd += (c % 7 != 3 && (rb || c % 3 != 0)) ? 2 : 0;
        bus(1'b1, OFS_CTRL, {30'h0, md});
        frame_start <= 1'b1;
        frame_broadcast <= bc;
        frame_symbols <= 9'h2;
        @(posedge hclk);
        frame_start <= 1'b0;
        fork
            begin
                for (int j = 0; j < nd; j++)
                begin
                    in_valid <= 1'b1;
                    in_bits  <= 3'(j * 5 + 1) & wm;
                    do @(posedge hclk); while (!in_ready);
                end
                in_valid <= 1'b0;
            end
            for (int n = 0; n < 2 * NUM_CAR; n++)
            begin
                do @(posedge hclk); while (!(out_valid && out_ready));
                p = s[6] ^ s[3];
                s = {s[5:0], p};
                dat = (n % 36) % 7 != 3 && (rb || (n % 36) % 3 != 0);
                wd = dat ? 3'(k * 5 + 1) & wm : {3{p}} & wm;
                k += dat;
                ex = ((n % 36) % 7 == 3) ? {12'h0, 6'(n % 36), 13'h0, n == 71}
                    : {12'h0, 6'(n % 36), 1'b1, !dat, wd,
                       8'(n % 36 + 1), n == 71};
                chk({12'h0, out_carrier, out_active, out_filler, out_bits,
                     out_gain, out_last}, ex);
            end
        join
        $display("frame done %0d %0d", md, bc);
    endtask : run_frame
    task automatic test_estimate();
        rx_tone_map_request_flag <= 1'b1;
        @(posedge hclk);
        rx_tone_map_request_flag <= 1'b0;
        // Every fourth tone poor
        for (int c = 0; c < NUM_CAR; c++)
        begin
            snr_valid   <= 1'b1;
            snr_carrier <= 6'(c);
            snr_value   <= (c % 4 == 0) ? 8'h05 : 8'h20 + 8'(c);
            snr_last    <= (c == NUM_CAR - 1);
            @(posedge hclk);
        end
        snr_valid <= 1'b0;
        snr_last  <= 1'b0;
        rdchk(OFS_STATUS, 32'h1, 32'h1);
        rdchk(OFS_RESP, 32'hf03, 32'hf02);
        rdchk(OFS_MAP_LO, '1, 32'heeee_eeee);
        rdchk(OFS_MAP_HI, 32'hf, 32'he);
        bus(1'b1, OFS_STATUS, 32'h1);
        rdchk(OFS_STATUS, 32'h1, 32'h0);
        for (int c = 0; c < 2; c++)
        begin
            rx_sym_valid   <= 1'b1;
            rx_sym_carrier <= 6'(c);
            @(posedge hclk);
            rx_sym_valid <= 1'b0;
            @(posedge hclk);
            chk({30'h0, rx_keep_valid, rx_keep}, 32'(2 + c));
        end
        $display("test_estimate done");
    endtask : test_estimate
    task automatic end_sim();
        $display("checks %0d bad %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Watchdog; tests take about a thousand cycles
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_count++;
        $display("BAD %0t timeout", $time);
        end_sim();
    end
    initial
    begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, in_valid} = '0;
        {in_bits, frame_start, frame_broadcast, frame_symbols} = '0;
        {snr_valid, snr_carrier, snr_value, snr_last} = '0;
        {rx_sym_valid, rx_sym_carrier, rx_tone_map_request_flag} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        for (int m = 1; m < 4; m++)
            run_frame(2'(m), 1'b0);
        run_frame(2'h3, 1'b1);
        test_estimate();
        end_sim();
    end
endmodule : tone_mapped_carrier_mapper_bench
`default_nettype wire
